// ---- inc/acr_pkg.sv ----
package acr_pkg;

    // register byte offsets on the peripheral bus
    localparam logic [7:0] ACR_OFS_CTRL = 8'h00;
    localparam logic [7:0] ACR_OFS_DIV = 8'h04;
    localparam logic [7:0] ACR_OFS_STAT = 8'h08;
    localparam logic [7:0] ACR_OFS_RES = 8'h0c;

    // control register field positions
    localparam int ACR_CTRL_GO = 0;
    localparam int ACR_CTRL_CS = 1;
    localparam int ACR_CTRL_IC = 2;
    localparam int ACR_CTRL_FM_LO = 3;
    localparam int ACR_CTRL_FM_HI = 4;
    localparam int ACR_CTRL_IE = 5;
    localparam int ACR_CTRL_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int ACR_CTRL_GIE = 7;

    // status register field positions
    localparam int ACR_STAT_DONE = 0;
    localparam int ACR_STAT_BUSY = 1;
    localparam int ACR_STAT_IRQ = 2;

    // values after reset
    localparam logic [5:0] ACR_DIV_RST = 6'h01;
    localparam logic [15:0] ACR_RES_RST = 16'h0000;

    // converter geometry
    localparam int ACR_RES_BITS = 12;
    localparam logic [3:0] ACR_MSB_INDEX = 4'hb;
    localparam logic [11:0] ACR_MID_CODE = 12'h800;
    localparam int ACR_LEFT_SHIFT = 4;
    localparam int ACR_SW_SHIFT = 3;
    // two's complement limits of the signed result
    localparam logic signed [11:0] ACR_TC_MIN = -12'sd2047;
    localparam logic signed [11:0] ACR_TC_MAX = 12'sd2046;

    // control bits as seen by the converter logic
    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic ie;
        logic [1:0] fm;
        logic ic;
        logic cs;
    } acr_ctrl_t;

    // sleep and wake signalling towards the core
    typedef struct packed {
        logic wake;
        logic vector_isr;
    } acr_wake_t;

    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_CONV = 2'b01,
        ACR_DONE = 2'b11
    } acr_state_t;

endpackage

// ---- verilog/acr_sync3.sv ----
`timescale 1ns/100ps
module acr_sync3 import acr_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // input from another domain
    output logic [WIDTH-1:0] level // settled level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] held;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a change only counts once the last two stages agree; the agreed value is
    // passed on at once, since a fourth flop would not fit the shortest bit period
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            level[i] = (stage2[i] == stage3[i]) ? stage3[i] : held[i];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            held <= '0;
        end else begin
            held <= level;
        end
    end
endmodule // acr_sync3

// ---- verilog/acr_format.sv ----
`timescale 1ns/100ps
module acr_format import acr_pkg::*; (
    input wire logic [11:0] raw, // offset-binary code from the approximation
    input wire logic ic, // differential mode
    input wire logic [1:0] fm, // result format select
    output logic [15:0] word // formatted result pair
);
    logic signed [11:0] sv;
    logic signed [11:0] clamped;
    logic [10:0] mag;
    logic neg;

    always_comb begin
        // differential codes centre on mid scale
        sv = $signed(raw ^ ACR_MID_CODE);
        // R19 two's complement range
        clamped = sv;
        if (sv < ACR_TC_MIN) begin
            clamped = ACR_TC_MIN;
        end else if (sv > ACR_TC_MAX) begin
            clamped = ACR_TC_MAX;
        end
        neg = clamped[11];
        mag = neg ? 11'(-clamped) : clamped[10:0];
        word = '0;
        if (!ic) begin
            // R13 R14 R21 single ended, zero filled
            word = fm[0] ? {4'h0, raw} : {raw, 4'h0};
        end else begin
            case (fm)
                // R15 two's complement, left zero filled, right sign extended
                2'b00: word = {clamped, 4'h0};
                2'b01: word = {{4{clamped[11]}}, clamped};
                // R16 R18 sign/magnitude, sign in top bit
                2'b10: word = {neg, mag, 4'h0};
                2'b11: word = {neg, 4'h0, mag};
                default: word = '0;
            endcase
        end
    end
endmodule // acr_format

// ---- verilog/acr_adc_ctl.sv ----
// Overview of operation
// R01 - clock select 1 picks the RC conversion clock, 0 the oscillator divider
// R02 - oscillator clock divided by two times (divider setting plus one)
// R03 - software should load only odd divider settings for accuracy
// R04 - each result bit takes one period of the conversion clock
// R05 - control logic follows the chosen clock; RC choice delays control changes
// R06 - oscillator-derived conversion clock tracks any system clock change
// R07 - done flag set at every conversion end regardless of interrupt enable
// R08 - only software clears the done flag, reading the result does not
// R09 - interrupt requested only while done flag and its enable are both set
// R10 - conversions run in sleep only with the RC clock selected
// R11 - sleep wake without service routine when global enable is clear
// R12 - sleep wake then vector to service routine when global enable set
// R13 - single ended, format bit 0 clear: result left justified
// R14 - single ended, format bit 0 set: result right justified
// R15 - differential 00 left two's complement, 01 right two's complement
// R16 - differential 10 left sign/magnitude, 11 right sign/magnitude
// R17 - software writes stored right justified; left formats read shifted by three
// R18 - right sign/magnitude: high byte bit 7 is sign, magnitude up to 2047
// R19 - two's complement: top bit is polarity, range -2047 to 2046
// R20 - differential select 1 gives signed results, 0 single ended positive
// R21 - unused result bits zero filled or sign extended consistently
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module acr_adc_ctl import acr_pkg::*; (
    input wire logic ref_clk, // system oscillator clock
    input wire logic resetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic rc_clk_pin, // dedicated RC conversion clock
    input wire logic cmp_above, // comparator: input above trial level
    input wire logic sleep_mode, // core is in sleep
    output logic [11:0] trial_code, // trial level to the analog front end
    output logic sample_hold, // high while a conversion runs
    output logic irq_request, // converter interrupt request
    output acr_wake_t wake_out // wake level and vector request
);
    acr_ctrl_t ctrl_sw;
    acr_ctrl_t ctrl_eff;
    logic [5:0] div_sw;
    logic [5:0] div_eff;
    logic go;
    logic done_flag;
    logic [15:0] result;
    acr_state_t state;
    logic [3:0] bit_idx;
    logic [11:0] sar;
    logic [11:0] next_sar;
    logic start_conv;
    logic [7:0] div_cnt;
    logic [7:0] div_last;
    logic div_tick;
    logic rc_level;
    logic rc_prev;
    logic rc_tick;
    logic conv_tick;
    logic cmp_level;
    logic [15:0] fmt_word;
    logic access;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic sel_ctrl;
    logic sel_div;
    logic sel_stat;
    logic sel_res;
    logic conv_end;
    logic next_done_flag;
    logic [31:0] next_prdata;

    acr_sync3 #(
        .WIDTH(2)
    ) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in({rc_clk_pin, cmp_above}),
        .level({rc_level, cmp_level})
    );

    // formatting is combinational on the working register; it is stored at DONE
    acr_format u_format (
        .raw(sar),
        .ic(ctrl_eff.ic),
        .fm(ctrl_eff.fm),
        .word(fmt_word)
    );

    // apb: registered ready, so every access phase lasts two cycles
    assign access = psel && penable && !pready;
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;
    // one select per register, shared by the write and refusal paths; reads decode paddr in their own case
    assign sel_ctrl = (paddr == ACR_OFS_CTRL);
    assign sel_div = (paddr == ACR_OFS_DIV);
    assign sel_stat = (paddr == ACR_OFS_STAT);
    assign sel_res = (paddr == ACR_OFS_RES);
    // refused accesses still complete, so a stray address cannot hang the bus
    assign mapped = sel_ctrl || sel_div || sel_stat || sel_res;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // a master that holds penable past pready starts a second access in the next cycle
            pready <= access;
            pslverr <= access && !mapped;
        end
    end

    always_comb begin
        next_prdata = '0;
        case (paddr)
            ACR_OFS_CTRL: begin
                next_prdata[ACR_CTRL_GO] = go;
                next_prdata[ACR_CTRL_CS] = ctrl_sw.cs;
                next_prdata[ACR_CTRL_IC] = ctrl_sw.ic;
                next_prdata[ACR_CTRL_FM_HI:ACR_CTRL_FM_LO] = ctrl_sw.fm;
                next_prdata[ACR_CTRL_IE] = ctrl_sw.ie;
                next_prdata[ACR_CTRL_PERIPHERAL_IRQ_ENABLE] = ctrl_sw.peripheral_irq_enable;
                next_prdata[ACR_CTRL_GIE] = ctrl_sw.global_irq_enable;
            end
            ACR_OFS_DIV: next_prdata[5:0] = div_sw;
            ACR_OFS_STAT: begin
                next_prdata[ACR_STAT_DONE] = done_flag;
                next_prdata[ACR_STAT_BUSY] = (state == ACR_CONV);
                next_prdata[ACR_STAT_IRQ] = irq_request;
            end
            ACR_OFS_RES: next_prdata[15:0] = result;
            default: next_prdata = '0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= '0;
        // prdata holds between reads, so a late sampler still sees the last word
        end else if (rd_en) begin
            prdata <= next_prdata;
        end
    end

    // software copy of the control bits
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_sw <= '0;
            div_sw <= ACR_DIV_RST;
        end else if (wr_en) begin
            if (sel_ctrl) begin
                ctrl_sw.cs <= pwdata[ACR_CTRL_CS];
                ctrl_sw.ic <= pwdata[ACR_CTRL_IC];
                ctrl_sw.fm <= pwdata[ACR_CTRL_FM_HI:ACR_CTRL_FM_LO];
                ctrl_sw.ie <= pwdata[ACR_CTRL_IE];
                ctrl_sw.peripheral_irq_enable <= pwdata[ACR_CTRL_PERIPHERAL_IRQ_ENABLE];
                ctrl_sw.global_irq_enable <= pwdata[ACR_CTRL_GIE];
            end
            // R03 even settings accepted, accuracy is software's concern
            if (sel_div) begin
                div_sw <= pwdata[5:0];
            end
        end
    end

    // R05 on the RC clock, control changes land at its next edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_eff <= '0;
            div_eff <= ACR_DIV_RST;
        // on the oscillator clock the copy simply follows every cycle
        end else if (!ctrl_eff.cs || rc_tick) begin
            ctrl_eff <= ctrl_sw;
            div_eff <= div_sw;
        end
    end

    // R06 divider counts system cycles, so it tracks the system clock
    assign div_last = 8'({div_eff, 1'b1});
    assign div_tick = (div_cnt == div_last);

    // R02 period of 2 * (setting + 1) system cycles
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= '0;
        // a setting lowered mid-count would otherwise run on to wrap-around
        end else if (ctrl_eff.cs || div_tick || div_cnt > div_last) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rc_prev <= 1'b0;
        end else begin
            rc_prev <= rc_level;
        end
    end

    // rc_prev resets low like the idle pin, so no false edge follows reset
    assign rc_tick = rc_level && !rc_prev;

    // R01 pick the conversion clock; R10 oscillator clock halts in sleep
    // a conversion caught by sleep on the oscillator clock resumes on wake
    assign conv_tick = ctrl_eff.cs ? rc_tick : (div_tick && !sleep_mode);

    // go is set by software and cleared by hardware at the end
    // a start written in the ending cycle is lost; software polls go low first
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            go <= 1'b0;
        end else if (conv_end) begin
            go <= 1'b0;
        end else if (wr_en && sel_ctrl && pwdata[ACR_CTRL_GO]) begin
            go <= 1'b1;
        end
    end

    // launching the trial level with each decision leaves the comparator the
    // whole bit period to cross its synchroniser before the next tick
    assign start_conv = (state == ACR_IDLE) && go && conv_tick;

    always_comb begin
        next_sar = sar;
        if (start_conv) begin
            next_sar = ACR_MID_CODE;
        end else if (state == ACR_CONV && conv_tick) begin
            if (!cmp_level) begin
                next_sar[bit_idx] = 1'b0;
            end
            if (bit_idx != 4'h0) begin
                next_sar[bit_idx - 4'h1] = 1'b1;
            end
        end
    end

    // R04 one conversion clock period per result bit
    // the single DONE cycle stores the result and sets the flag once
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ACR_IDLE;
            bit_idx <= '0;
        end else begin
            case (state)
                ACR_IDLE: begin
                    if (start_conv) begin
                        state <= ACR_CONV;
                        bit_idx <= ACR_MSB_INDEX;
                    end
                end
                ACR_CONV: begin
                    if (conv_tick) begin
                        if (bit_idx == 4'h0) begin
                            state <= ACR_DONE;
                        end else begin
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end
                end
                ACR_DONE: state <= ACR_IDLE;
                default: state <= ACR_IDLE;
            endcase
        end
    end

    assign conv_end = (state == ACR_DONE);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sar <= '0;
            trial_code <= '0;
            sample_hold <= 1'b0;
        end else begin
            // the pins carry the same value as the working register
            sar <= next_sar;
            trial_code <= next_sar;
            sample_hold <= (state == ACR_CONV);
        end
    end

    // R20 R21 conversion result lands in the chosen format
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            result <= ACR_RES_RST;
        end else if (conv_end) begin
            // a conversion end outranks a software write in the same cycle
            result <= fmt_word;
        end else if (wr_en && sel_res) begin
            // R17 writes are right justified; left formats show them shifted
            if (ctrl_sw.fm[0]) begin
                result <= pwdata[15:0];
            end else begin
                result <= 16'(pwdata[15:0] << ACR_SW_SHIFT);
            end
        end
    end

    // R07 R08 set at every end, cleared only by a one written to status
    always_comb begin
        next_done_flag = done_flag;
        if (wr_en && sel_stat && pwdata[ACR_STAT_DONE]) begin
            next_done_flag = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (conv_end) begin
            next_done_flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            done_flag <= 1'b0;
        end else begin
            done_flag <= next_done_flag;
        end
    end

    // R09 request only while flag and enable are both set
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_request <= 1'b0;
        end else begin
            // from next_done_flag so the request rises at the edge that sets the flag
            irq_request <= next_done_flag && ctrl_sw.ie;
        end
    end

    // R11 R12 wake from sleep; vector to the routine only with global enable
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wake_out <= '0;
        end else begin
            // levels, not pulses: they fall once the core leaves sleep
            wake_out.wake <= sleep_mode && next_done_flag && ctrl_sw.ie && ctrl_sw.peripheral_irq_enable;
            wake_out.vector_isr <= sleep_mode && next_done_flag && ctrl_sw.ie &&
                                   ctrl_sw.peripheral_irq_enable && ctrl_sw.global_irq_enable;
        end
    end
endmodule // acr_adc_ctl

// ---- sim/acr_adc_ctl_props.sv ----
`timescale 1ns/100ps
module acr_adc_ctl_props import acr_pkg::*; (
    input wire logic ref_clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic rc_clk_pin, // rc clock pin
    input wire logic cmp_above, // comparator
    input wire logic sleep_mode, // core asleep
    input wire logic [11:0] trial_code, // trial level
    input wire logic sample_hold, // converting
    input wire logic irq_request, // interrupt request
    input wire acr_wake_t wake_out // wake and vector
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_after_access: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered");
    a_ready_needs_sel: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_wake_needs_irq: assert property (wake_out.wake |-> irq_request)
        else $error("wake without interrupt request");
    a_vector_needs_wake: assert property (wake_out.vector_isr |-> wake_out.wake)
        else $error("vector without wake");
    a_wake_needs_sleep: assert property (wake_out.wake |-> $past(sleep_mode))
        else $error("wake while awake");
    a_irq_drop_on_write: assert property ($fell(irq_request) |->
        $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
        else $error("interrupt dropped without a write");

    c_wake: cover property ($rose(wake_out.wake));
    c_vector: cover property ($rose(wake_out.vector_isr));
    c_refused: cover property (pslverr);
endmodule // acr_adc_ctl_props

bind acr_adc_ctl acr_adc_ctl_props u_props (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rc_clk_pin(rc_clk_pin), .cmp_above(cmp_above),
    .sleep_mode(sleep_mode), .trial_code(trial_code), .sample_hold(sample_hold),
    .irq_request(irq_request), .wake_out(wake_out));

// ---- sim/acr_afe_model.sv ----
`timescale 1ns/100ps
module acr_afe_model (
    input wire logic [11:0] trial_code, // trial level from the converter
    input wire logic [11:0] vin, // analog input expressed as a code
    output logic cmp_above, // input at or above the trial level
    output logic rc_clk_pin // free running rc conversion clock
);
    assign cmp_above = vin >= trial_code;
    // rc oscillator free running, phase unrelated to the system clock
    initial begin
        rc_clk_pin = 1'b0;
        #3;
        forever #35 rc_clk_pin = ~rc_clk_pin;
    end
endmodule // acr_afe_model

// ---- sim/acr_adc_ctl_tb_top.sv ----
`timescale 1ns/100ps
module acr_adc_ctl_tb_top import acr_pkg::*;;
    logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, rc_clk_pin, cmp_above, sample_hold, irq_request;
    logic [11:0] trial_code, vin = 0;
    acr_wake_t wake_out;
    int num_errors = 0, checks_done = 0, cycles = 0, hold_cnt = 0, i, m, v, p, k;

    acr_adc_ctl dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_clk_pin(rc_clk_pin), .cmp_above(cmp_above),
        .sleep_mode(sleep_mode), .trial_code(trial_code), .sample_hold(sample_hold),
        .irq_request(irq_request), .wake_out(wake_out));
    acr_afe_model afe (.trial_code(trial_code), .vin(vin), .cmp_above(cmp_above),
        .rc_clk_pin(rc_clk_pin));

    initial forever #5 ref_clk = ~ref_clk;

    // run ceiling well above the longest expected sequence
    always @(posedge ref_clk) begin
        cycles++;
        if (sample_hold === 1'b1) hold_cnt <= hold_cnt + 1;
        if (cycles == 40000) begin
            num_errors++;
            finish_test();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // called just after a rising edge; leaves one idle edge behind
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task convert(input int ctrl, input int val);
        vin <= 12'(val);
        apb(1'b1, ACR_OFS_CTRL, 32'(ctrl | 1));
        do apb(1'b0, ACR_OFS_CTRL, 32'h0); while (rd[ACR_CTRL_GO] !== 1'b0);
    endtask

    function automatic logic [15:0] fmt(int code, int ic, int fm);
        int s, mg;
        s = code - 2048;
        if (s < -2047) s = -2047;
        if (s > 2046) s = 2046;
        mg = s < 0 ? -s : s;
        if (ic == 0) return 16'(fm % 2 ? code : code << 4);
        case (fm)
            0: return 16'(s << 4);
            1: return 16'(s);
            2: return 16'((s < 0 ? 32'h8000 : 32'h0) | (mg << 4));
            default: return 16'((s < 0 ? 32'h8000 : 32'h0) | mg);
        endcase
    endfunction

    task finish_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h5389));
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rdchk(ACR_OFS_CTRL, 32'h0);
        rdchk(ACR_OFS_DIV, 32'(ACR_DIV_RST));
        rdchk(ACR_OFS_STAT, 32'h0);
        rdchk(ACR_OFS_RES, 32'(ACR_RES_RST));
        apb(1'b0, 8'h10, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("test reset and refusal done");
        // last two runs hit the two's complement clamps
        for (i = 0; i < 10; i++) begin
            v = i < 8 ? $urandom % 4096 : (i == 8 ? 0 : 4095);
            m = i < 8 ? i : i - 4;
            convert((m & 4) | ((m & 3) << ACR_CTRL_FM_LO) | ((i % 2) << ACR_CTRL_IE), v);
            rdchk(ACR_OFS_RES, 32'(fmt(v, m / 4, m % 4)));
            check(trial_code, 32'(v));
            rdchk(ACR_OFS_STAT, 32'(1 | ((i % 2) << ACR_STAT_IRQ)));
            check(irq_request, 32'(i % 2));
            apb(1'b1, ACR_OFS_STAT, 32'h1);
            rdchk(ACR_OFS_STAT, 32'h0);
            check(irq_request, 32'h0);
        end
        $display("test formats done");
        for (m = 0; m < 4; m++) begin
            apb(1'b1, ACR_OFS_CTRL, 32'(m << ACR_CTRL_FM_LO));
            apb(1'b1, ACR_OFS_RES, 32'h123);
            rdchk(ACR_OFS_RES, m % 2 ? 32'h123 : 32'h123 << 3);
        end
        $display("test result writes done");
        // only odd divider settings are loaded
        for (k = 1; k < 64; k += 62) begin
            p = 2 * (k + 1);
            apb(1'b1, ACR_OFS_DIV, 32'(k));
            v = hold_cnt;
            convert(0, $urandom % 4096);
            check(hold_cnt - v >= 12 * p && hold_cnt - v <= 12 * p + 3, 32'h1);
            apb(1'b1, ACR_OFS_STAT, 32'h1);
        end
        $display("test divider done");
        apb(1'b1, ACR_OFS_DIV, 32'h1);
        sleep_mode <= 1'b1;
        apb(1'b1, ACR_OFS_CTRL, 32'h1);
        repeat (300) @(posedge ref_clk);
        rdchk(ACR_OFS_CTRL, 32'h1);
        sleep_mode <= 1'b0;
        convert(0, 5);
        rdchk(ACR_OFS_STAT, 32'h1);
        apb(1'b1, ACR_OFS_STAT, 32'h1);
        $display("test oscillator sleep done");
        for (m = 0; m < 2; m++) begin
            v = $urandom % 4096;
            vin <= 12'(v);
            sleep_mode <= 1'b1;
            apb(1'b1, ACR_OFS_CTRL, 32'h63 | 32'(m << ACR_CTRL_GIE));
            k = 0;
            while (wake_out.wake !== 1'b1 && k < 3000) begin
                @(posedge ref_clk);
                k++;
            end
            check(wake_out, 32'(2 | m));
            check(irq_request, 32'h1);
            sleep_mode <= 1'b0;
            rdchk(ACR_OFS_RES, 32'(fmt(v, 0, 0)));
            apb(1'b1, ACR_OFS_STAT, 32'h1);
            rdchk(ACR_OFS_STAT, 32'h0);
        end
        $display("test rc sleep wake done");
        finish_test();
    end
endmodule // acr_adc_ctl_tb_top
